// ### rtc_pkg.sv
// shared constants of the calendar clock unit: timing, register map, fields
package rtc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SECOND_NS = 1000000000;
  localparam int TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TIME_OFS = 8'h04;
  localparam logic [7:0] DAY_OFS = 8'h08;
  localparam logic [7:0] DST_FWD_OFS = 8'h0C;
  localparam logic [7:0] DST_BACK_OFS = 8'h10;
  localparam logic [7:0] ALARM_TIME_OFS = 8'h14;
  localparam logic [7:0] ALARM_DAY_OFS = 8'h18;
  localparam logic [7:0] INT_STATUS_OFS = 8'h1C;
  localparam logic [7:0] INT_CLEAR_OFS = 8'h20;
  localparam logic [7:0] INT_ENABLE_OFS = 8'h24;
  localparam logic [7:0] STATUS_OFS = 8'h28;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_DST_BIT = 1;
  localparam int CTRL_ALARM_BIT = 2;
  localparam int SEC_LSB = 0;
  localparam int MIN_LSB = 8;
  localparam int HOUR_LSB = 16;
  localparam int DAY_LSB = 0;
  localparam int INT_ALARM_BIT = 0;
  localparam int INT_FWD_BIT = 1;
  localparam int INT_BACK_BIT = 2;
  localparam int INT_SEC_BIT = 3;
  localparam int INT_W = 4;
  localparam int STATUS_REPEAT_BIT = 0;

  // ****************************************************************
  // limits and reset values
  // ****************************************************************
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [5:0] MIN_MAX = 6'h3B;
  localparam logic [5:0] HOUR_MAX = 6'h17;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [5:0] TIME_FIELD_RST = 6'h00;
  localparam logic [15:0] DAY_RST = 16'h0000;
  localparam logic [INT_W-1:0] INT_RST = 4'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : rtc_pkg

// ### rtc_tick_gen.sv
// one-second tick prescaler for the calendar clock unit
`timescale 1ns/1ns
module rtc_tick_gen
  import rtc_pkg::*;
#(
  parameter int CYCLES = TICK_CYCLES
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  output logic tick
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count_reg;

  // count hclk cycles; held at zero while stopped so a restart is a full second
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_reg <= '0;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      count_reg <= '0;
      tick <= 1'b0;
    end
    else if (count_reg == LAST)
    begin
      count_reg <= '0;
      tick <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + CW'(1);
      tick <= 1'b0;
    end
  end

endmodule : rtc_tick_gen

// ### rtc_ahb_port.sv
// ahb-lite slave front end: address phase capture, zero wait states
`timescale 1ns/1ns
module rtc_ahb_port
  import rtc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic rd_en,
  output logic [7:0] rd_addr,
  output logic wr_en,
  output logic [7:0] wr_addr
);

  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic take;

  // only htrans[1] is decoded, so seq counts as a transfer as nonseq does; busy and seq never come from this master
  assign take = hsel & hready & htrans[1];
  assign rd_en = take & ~hwrite;
  assign rd_addr = haddr[7:0];

  // a write is applied in its data phase, when hwdata stands
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= take & hwrite;
      if (take & hwrite)
        wr_addr_reg <= haddr[7:0];
    end
  end

  assign wr_en = wr_pend_reg;
  assign wr_addr = wr_addr_reg;

endmodule : rtc_ahb_port

// ### rtc_calendar_clock_unit.sv
// calendar clock unit: time of day, daylight saving, alarm, ahb-lite regs
//
// Contract
// - forward and fall-back day and hour configurable
// - forward instant skips one whole hour
// - fall-back instant repeats hour exactly once
// - after repeat, next rollover advances normally
// - saving disabled gives plain hour rollovers
// - reprogrammable alarm raises processor interrupt
// - forward jump independent of fall-back state
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module rtc_calendar_clock_unit
  import rtc_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // increment with wrap at a limit; used for every time field
  function automatic logic [5:0] inc_wrap(input logic [5:0] v,
                                          input logic [5:0] lim);
    inc_wrap = (v == lim) ? 6'h00 : v + 6'h01;
  endfunction : inc_wrap

  // pack a time of day into the register layout
  function automatic logic [31:0] pack_time(input logic [5:0] s,
                                            input logic [5:0] m,
                                            input logic [5:0] h);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[SEC_LSB +: 6] = s;
    w[MIN_LSB +: 6] = m;
    w[HOUR_LSB +: 5] = h[4:0];
    pack_time = w;
  endfunction : pack_time

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic rd_en, wr_en, tick;
  logic [7:0] rd_addr, wr_addr;
  logic [2:0] ctrl_reg;
  logic [5:0] sec_reg, min_reg, hour_reg;
  logic [15:0] day_reg, fwd_day_reg, back_day_reg;
  logic [5:0] fwd_hour_reg, back_hour_reg;
  logic [5:0] al_sec_reg, al_min_reg, al_hour_reg;
  logic [15:0] al_day_reg;
  logic [INT_W-1:0] int_status_reg, int_enable_reg;
  logic repeat_reg;
  logic [5:0] sec_next, min_next, hour_next;
  logic [15:0] day_next;
  logic [5:0] n_sec, n_min, n_hour;
  logic [15:0] n_day;
  logic carry_s, carry_m, carry_h;
  logic dst_en, fwd_hit, back_hit, alarm_hit, time_wr;
  logic [INT_W-1:0] int_set, int_clr;
  logic [31:0] rd_mux;

  // ****************************************************************
  // bus front end and second tick
  // ****************************************************************
  rtc_ahb_port u_port (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en), .wr_addr(wr_addr)
  );

  rtc_tick_gen #(.CYCLES(TICK_COUNT)) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(ctrl_reg[CTRL_RUN_BIT]),
    .tick(tick)
  );

  assign dst_en = ctrl_reg[CTRL_DST_BIT];
  assign time_wr = wr_en & ((wr_addr == TIME_OFS) | (wr_addr == DAY_OFS));

  // ****************************************************************
  // time of day arithmetic
  // ****************************************************************
  // plain field carry
  always_comb
  begin
    carry_s = (sec_reg == SEC_MAX);
    carry_m = carry_s & (min_reg == MIN_MAX);
    carry_h = carry_m & (hour_reg == HOUR_MAX);
    n_sec = inc_wrap(sec_reg, SEC_MAX);
    n_min = carry_s ? inc_wrap(min_reg, MIN_MAX) : min_reg;
    n_hour = carry_m ? inc_wrap(hour_reg, HOUR_MAX) : hour_reg;
    n_day = carry_h ? day_reg + 16'h0001 : day_reg;
  end

  // instants compare against the plain next time at an hour edge
  // both adjustments gated off while saving is disabled
  assign fwd_hit = dst_en & carry_m & (n_day == fwd_day_reg)
                   & (n_hour == fwd_hour_reg);
  assign back_hit = dst_en & carry_m & (n_day == back_day_reg)
                    & (n_hour == back_hour_reg);

  // adjusted next time
  always_comb
  begin
    sec_next = n_sec;
    min_next = n_min;
    hour_next = n_hour;
    day_next = n_day;
    if (fwd_hit)
    begin
      hour_next = inc_wrap(n_hour, HOUR_MAX);
      if (n_hour == HOUR_MAX)
        day_next = n_day + 16'h0001;
    end
    // step back once by staying in the current hour
    else if (back_hit & ~repeat_reg)
    begin
      hour_next = hour_reg;
      day_next = day_reg;
    end
  end

  // alarm when the running time reaches the programmed value
  assign alarm_hit = tick & ctrl_reg[CTRL_ALARM_BIT]
                     & (sec_next == al_sec_reg) & (min_next == al_min_reg)
                     & (hour_next == al_hour_reg) & (day_next == al_day_reg);

  // ****************************************************************
  // time registers
  // ****************************************************************
  // software load wins over a tick in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sec_reg <= TIME_FIELD_RST;
      min_reg <= TIME_FIELD_RST;
      hour_reg <= TIME_FIELD_RST;
      day_reg <= DAY_RST;
    end
    else if (wr_en & (wr_addr == TIME_OFS))
    begin
      sec_reg <= hwdata[SEC_LSB +: 6];
      min_reg <= hwdata[MIN_LSB +: 6];
      hour_reg <= {1'b0, hwdata[HOUR_LSB +: 5]};
    end
    else if (wr_en & (wr_addr == DAY_OFS))
      day_reg <= hwdata[DAY_LSB +: 16];
    else if (tick)
    begin
      sec_reg <= sec_next;
      min_reg <= min_next;
      hour_reg <= hour_next;
      day_reg <= day_next;
    end
  end

  // repeat marker: the second pass of the instant clears it
  // also cleared by a time load or by disabling, so no stale repeat
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      repeat_reg <= 1'b0;
    else if (time_wr | ~dst_en)
      repeat_reg <= 1'b0;
    else if (tick & back_hit)
      repeat_reg <= ~repeat_reg;
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // saving instants and control
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg <= CTRL_RST;
      fwd_day_reg <= DAY_RST;
      fwd_hour_reg <= TIME_FIELD_RST;
      back_day_reg <= DAY_RST;
      back_hour_reg <= TIME_FIELD_RST;
    end
    else if (wr_en)
    begin
      case (wr_addr)
        CTRL_OFS: ctrl_reg <= hwdata[2:0];
        DST_FWD_OFS:
        begin
          fwd_day_reg <= hwdata[DAY_LSB +: 16];
          fwd_hour_reg <= {1'b0, hwdata[HOUR_LSB +: 5]};
        end
        DST_BACK_OFS:
        begin
          back_day_reg <= hwdata[DAY_LSB +: 16];
          back_hour_reg <= {1'b0, hwdata[HOUR_LSB +: 5]};
        end
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // alarm value, writable at any time
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      al_sec_reg <= TIME_FIELD_RST;
      al_min_reg <= TIME_FIELD_RST;
      al_hour_reg <= TIME_FIELD_RST;
      al_day_reg <= DAY_RST;
    end
    else if (wr_en & (wr_addr == ALARM_TIME_OFS))
    begin
      al_sec_reg <= hwdata[SEC_LSB +: 6];
      al_min_reg <= hwdata[MIN_LSB +: 6];
      al_hour_reg <= {1'b0, hwdata[HOUR_LSB +: 5]};
    end
    else if (wr_en & (wr_addr == ALARM_DAY_OFS))
      al_day_reg <= hwdata[DAY_LSB +: 16];
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  always_comb
  begin
    int_set = INT_RST;
    int_set[INT_ALARM_BIT] = alarm_hit;
    int_set[INT_FWD_BIT] = tick & fwd_hit;
    int_set[INT_BACK_BIT] = tick & back_hit & ~repeat_reg;
    int_set[INT_SEC_BIT] = tick;
    int_clr = (wr_en & (wr_addr == INT_CLEAR_OFS)) ? hwdata[INT_W-1:0]
                                                    : INT_RST;
  end

  // sticky status; a set in the clearing cycle wins so no event is lost
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_status_reg <= INT_RST;
    else
      int_status_reg <= (int_status_reg & ~int_clr) | int_set;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_enable_reg <= INT_RST;
    else if (wr_en & (wr_addr == INT_ENABLE_OFS))
      int_enable_reg <= hwdata[INT_W-1:0];
  end

  // level interrupt, one cycle behind the status it reflects
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(int_status_reg & int_enable_reg);
  end

  // ****************************************************************
  // read path and bus response
  // ****************************************************************
  // write-only clear and unmapped offsets read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (rd_addr)
      CTRL_OFS: rd_mux[2:0] = ctrl_reg;
      TIME_OFS: rd_mux = pack_time(sec_reg, min_reg, hour_reg);
      DAY_OFS: rd_mux[15:0] = day_reg;
      DST_FWD_OFS: rd_mux = {11'h000, fwd_hour_reg[4:0], fwd_day_reg};
      DST_BACK_OFS: rd_mux = {11'h000, back_hour_reg[4:0], back_day_reg};
      ALARM_TIME_OFS: rd_mux = pack_time(al_sec_reg, al_min_reg,
                                         al_hour_reg);
      ALARM_DAY_OFS: rd_mux[15:0] = al_day_reg;
      INT_STATUS_OFS: rd_mux[INT_W-1:0] = int_status_reg;
      INT_ENABLE_OFS: rd_mux[INT_W-1:0] = int_enable_reg;
      STATUS_OFS: rd_mux[STATUS_REPEAT_BIT] = repeat_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // data captured at the address phase, standing through the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_en)
      hrdata <= rd_mux;
  end

  // zero wait states, always okay; hsize is not needed for word access
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule : rtc_calendar_clock_unit

// ### rtc_calendar_clock_unit_sva.sv
// checker: bus and interrupt relations of the calendar clock unit
`timescale 1ns/1ns
module rtc_calendar_clock_unit_sva
  import rtc_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq
);
  // ****************************************************************
  // data phase tracking
  // ****************************************************************
  logic dph_rd_reg;
  logic dph_wr_reg;
  logic [7:0] dph_addr_reg;
  logic [3:0] en_reg;
  logic [3:0] en_seen_reg;
  logic taken;
  logic clr_wr;
  assign taken = hsel && hready && htrans[1];
  assign clr_wr = dph_wr_reg && (dph_addr_reg == INT_CLEAR_OFS ||
                                 dph_addr_reg == INT_ENABLE_OFS);
  // zero wait states, so the data phase is always the next cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_rd_reg <= 1'b0;
      dph_wr_reg <= 1'b0;
      dph_addr_reg <= 8'h00;
      en_reg <= 4'h0;
      en_seen_reg <= 4'h0;
    end
    else
    begin
      dph_rd_reg <= taken && !hwrite;
      dph_wr_reg <= taken && hwrite;
      dph_addr_reg <= haddr[7:0];
      // old value seen by a read issued at this edge
      en_seen_reg <= en_reg;
      if (dph_wr_reg && dph_addr_reg == INT_ENABLE_OFS)
        en_reg <= hwdata[3:0];
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  chk_ready_out: assert property ($past(hresetn) |-> hreadyout)
    else $error("hreadyout low after reset");
  chk_unmapped_zero: assert property
    (dph_rd_reg && dph_addr_reg > STATUS_OFS |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_hrdata_hold: assert property
    (!$past(taken && !hwrite) |-> $stable(hrdata))
    else $error("read data changed without a read");
  chk_irq_masked: assert property ((en_reg == 4'h0) [*2] |-> !irq)
    else $error("irq high with all sources disabled");
  chk_enable_readback: assert property
    (dph_rd_reg && dph_addr_reg == INT_ENABLE_OFS |->
     hrdata == {28'h0000000, en_seen_reg})
    else $error("enable register readback wrong");
  chk_irq_fall_cause: assert property ($fell(irq) |-> $past(clr_wr, 2))
    else $error("irq dropped without clear or enable write");
  chk_time_range: assert property
    (dph_rd_reg && dph_addr_reg == TIME_OFS |-> hrdata[5:0] <= SEC_MAX &&
     hrdata[13:8] <= MIN_MAX && hrdata[20:16] <= HOUR_MAX[4:0])
    else $error("time field out of range");

  cover property ($rose(irq));
  cover property ($fell(irq));
  cover property (dph_rd_reg && dph_addr_reg == TIME_OFS);
endmodule : rtc_calendar_clock_unit_sva

bind rtc_calendar_clock_unit rtc_calendar_clock_unit_sva #(
  .TICK_COUNT(TICK_COUNT)
) u_rtc_calendar_clock_unit_sva (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

// ### rtc_calendar_clock_unit_test.sv
// self-checking bench for the calendar clock unit
`timescale 1ns/1ns
module rtc_calendar_clock_unit_test
  import rtc_pkg::*;
();
  // ****************************************************************
  // design and bus tasks
  // ****************************************************************
  localparam int TC = 16;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, t;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int fail_count, cmp_count;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  rtc_calendar_clock_unit #(.TICK_COUNT(TC)) u_rtc_calendar_clock_unit (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq));

  function automatic logic [31:0] tw(input logic [5:0] h,
    input logic [5:0] m, input logic [5:0] s);
    return {11'h000, h[4:0], 2'h0, m, 2'h0, s};
  endfunction : tw

  task give_verdict;
    $display("comparisons %0d errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task timeout(input string name);
    fail_count++;
    $display("Error %s expected event seen timeout", name);
    give_verdict();
  endtask : timeout

  // the master waits for hready however long it takes, up to a bound
  task wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
      timeout("hready");
  endtask : wait_ready

  task ahb_write(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask : ahb_write

  task ahb_read(input logic [7:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= 1'b0;
    htrans <= HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    wait_ready();
    d = hrdata;
  endtask : ahb_read

  // irq lags the status by a cycle, so look one edge later
  task irq_is(input logic lvl);
    @(posedge hclk);
    @(negedge hclk);
    check("irq", {31'h0, irq}, {31'h0, lvl});
    @(posedge hclk);
  endtask : irq_is

  // stop, clear flags, load day and time, then restart
  task set_time(input logic [15:0] d, input logic [31:0] tm,
    input logic [2:0] c);
    ahb_write(CTRL_OFS, 32'h0);
    ahb_write(INT_CLEAR_OFS, 32'hF);
    ahb_write(DAY_OFS, {16'h0000, d});
    ahb_write(TIME_OFS, tm);
    ahb_write(CTRL_OFS, {29'h0, c});
  endtask : set_time

  // one second: clear tick flag, wait for the tick irq, read time
  task step_expect(input logic [31:0] exp);
    int n;
    ahb_write(INT_CLEAR_OFS, 32'h8);
    @(posedge hclk);
    n = 0;
    do
    begin
      @(negedge hclk);
      n++;
    end
    while (irq !== 1'b1 && n < 4 * TC);
    if (irq !== 1'b1)
      timeout("tick");
    @(posedge hclk);
    ahb_read(TIME_OFS, t);
    check("time", t, exp);
  endtask : step_expect

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fail_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    ahb_read(CTRL_OFS, t);
    check("ctrl", t, 32'h0);
    ahb_read(8'h30, t);
    check("unmapped", t, 32'h0);
    ahb_write(DST_FWD_OFS, 32'h000E0001);
    ahb_write(DST_BACK_OFS, 32'h00100002);
    ahb_read(DST_FWD_OFS, t);
    check("forward cfg", t, 32'h000E0001);
    ahb_read(DST_BACK_OFS, t);
    check("back cfg", t, 32'h00100002);
    ahb_write(INT_ENABLE_OFS, 32'h8);
    ahb_read(INT_ENABLE_OFS, t);
    check("enable", t, 32'h8);
    set_time(16'h0005, tw(6'h17, 6'h3B, 6'h3A), 3'h1);
    step_expect(tw(6'h17, 6'h3B, 6'h3B));
    step_expect(tw(6'h00, 6'h00, 6'h00));
    ahb_read(DAY_OFS, t);
    check("day", t, 32'h6);
    set_time(16'h0002, tw(6'h0F, 6'h3B, 6'h3A), 3'h3);
    step_expect(tw(6'h0F, 6'h3B, 6'h3B));
    step_expect(tw(6'h0F, 6'h00, 6'h00));
    ahb_read(STATUS_OFS, t);
    check("repeat", t, 32'h1);
    ahb_read(INT_STATUS_OFS, t);
    check("back flag", t & 32'h4, 32'h4);
    ahb_write(INT_CLEAR_OFS, 32'h4);
    for (int i = 1; i < 3600; i++)
      step_expect(tw(6'h0F, 6'(i / 60), 6'(i % 60)));
    step_expect(tw(6'h10, 6'h00, 6'h00));
    ahb_read(STATUS_OFS, t);
    check("repeat", t, 32'h0);
    ahb_read(INT_STATUS_OFS, t);
    check("back flag", t & 32'h4, 32'h0);
    set_time(16'h0001, tw(6'h0D, 6'h3B, 6'h3B), 3'h3);
    step_expect(tw(6'h0F, 6'h00, 6'h00));
    ahb_read(INT_STATUS_OFS, t);
    check("forward flag", t & 32'h2, 32'h2);
    set_time(16'h0002, tw(6'h0F, 6'h3B, 6'h3B), 3'h1);
    step_expect(tw(6'h10, 6'h00, 6'h00));
    ahb_write(ALARM_DAY_OFS, 32'h7);
    ahb_write(ALARM_TIME_OFS, tw(6'h0A, 6'h00, 6'h01));
    set_time(16'h0007, tw(6'h0A, 6'h00, 6'h00), 3'h5);
    step_expect(tw(6'h0A, 6'h00, 6'h01));
    ahb_write(CTRL_OFS, 32'h0);
    ahb_write(INT_CLEAR_OFS, 32'h8);
    ahb_read(INT_STATUS_OFS, t);
    check("alarm flag", t, 32'h1);
    irq_is(1'b0);
    ahb_write(INT_ENABLE_OFS, 32'h1);
    irq_is(1'b1);
    ahb_write(INT_CLEAR_OFS, 32'h1);
    irq_is(1'b0);
    give_verdict();
  end
endmodule : rtc_calendar_clock_unit_test
